//--- core/lsi_led_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_led_ctrl
    import lsi_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link10_i,
    input wire logic link100_i,
    input wire logic link1000_i,
    input wire logic fiber_link_i,
    input wire logic full_duplex_i,
    input wire logic collision_i,
    input wire logic tx_act_i,
    input wire logic rx_act_i,
    input wire logic fiber_media_i,
    input wire logic [31:0] copper_irq_stat_i,
    input wire logic [15:0] fiber_irq_stat_i,
    output logic [2:0] indicator_o,
    output logic [2:0] indicator_oe_o
);

    // ****************************************************************
    // Register slave
    // ****************************************************************
    logic [31:0] func_q, time_q, pol_q, cen_q, fib_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, stat_w;
    logic wr_go, rd_go;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic known(input logic [7:0] a);
        return a == OFS_FUNC || a == OFS_TIME || a == OFS_POL ||
               a == OFS_CEN || a == OFS_FIB || a == OFS_STAT;
    endfunction

    // Address and data are taken together, so either arrival order works.
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign rd_go = s_axi_arvalid & ~rvalid_q;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            func_q <= RST_FUNC;
            time_q <= RST_TIME;
            pol_q <= RST_POL;
            cen_q <= RST_CEN;
            fib_q <= RST_FIB;
        end else if (wr_go) begin
            unique case (s_axi_awaddr)
                OFS_FUNC: func_q <= merge(func_q, s_axi_wdata, s_axi_wstrb);
                OFS_TIME: time_q <= merge(time_q, s_axi_wdata, s_axi_wstrb);
                OFS_POL: pol_q <= merge(pol_q, s_axi_wdata, s_axi_wstrb);
                OFS_CEN: cen_q <= merge(cen_q, s_axi_wdata, s_axi_wstrb);
                OFS_FIB: fib_q <= merge(fib_q, s_axi_wdata, s_axi_wstrb);
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (known(s_axi_awaddr) && s_axi_awaddr != OFS_STAT)
                       ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFS_FUNC: rdata_q <= func_q;
                OFS_TIME: rdata_q <= time_q;
                OFS_POL: rdata_q <= pol_q;
                OFS_CEN: rdata_q <= cen_q;
                OFS_FIB: rdata_q <= fib_q;
                OFS_STAT: rdata_q <= stat_w;
                default: rdata_q <= '0;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Millisecond time base
    // ****************************************************************
    logic [15:0] div_q;
    logic ms_tick;

    assign ms_tick = (div_q == 16'(TICK_CYC - 1));

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= '0;
        end else begin
            div_q <= ms_tick ? '0 : div_q + 16'h0001;
        end
    end

    // ****************************************************************
    // Activity stretching and blink clock
    // ****************************************************************
    // Ranges 2 to 5 end where the four segment periods do, so those are shared.
    function automatic logic [11:0] str_ms(input logic [2:0] c);
        unique case (c)
            3'h0: return '0;
            3'h1: return STR_MS_1;
            3'h2: return SEG_MS_0;
            3'h3: return SEG_MS_1;
            3'h4: return SEG_MS_2;
            3'h5: return SEG_MS_3;
            3'h6: return STR_MS_6;
            3'h7: return STR_MS_7;
        endcase
    endfunction

    logic [1:0] raw_act, act_s;
    logic [11:0] str_len;
    assign raw_act = {rx_act_i, tx_act_i};
    assign str_len = str_ms(time_q[T_STR_LO +: 3]);

    // The hold counts whole ms ticks, so a stretched pulse lasts up to one
    // tick less than the upper end of the chosen range.
    for (genvar g = 0; g < 2; g++) begin : g_str
        logic [11:0] hold_q;
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                hold_q <= '0;
            end else if (raw_act[g]) begin
                hold_q <= str_len;
            end else if (ms_tick && hold_q != '0) begin
                hold_q <= hold_q - 12'h001;
            end
        end
        assign act_s[g] = raw_act[g] | (hold_q != '0);
    end

    function automatic logic [11:0] blink_ms(input logic [2:0] c);
        unique case (c)
            3'h0: return BLK_MS_0;
            3'h1: return SEG_MS_0;
            3'h2: return SEG_MS_1;
            3'h3: return SEG_MS_2;
            default: return SEG_MS_3;
        endcase
    endfunction

    logic [11:0] blk_cnt_q, blk_ms;
    logic blink_q;
    // Reserved blink codes fall back to the slowest rate.
    assign blk_ms = blink_ms(time_q[T_BLINK_LO +: 3]);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blk_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (ms_tick) begin
            if (blk_cnt_q >= blk_ms - 12'h001) begin
                blk_cnt_q <= '0;
                blink_q <= ~blink_q;
            end else begin
                blk_cnt_q <= blk_cnt_q + 12'h001;
            end
        end
    end

    // ****************************************************************
    // Speed blink sequencer
    // ****************************************************************
    function automatic logic [11:0] seg_ms(input logic [1:0] c);
        unique case (c)
            2'h0: return SEG_MS_0;
            2'h1: return SEG_MS_1;
            2'h2: return SEG_MS_2;
            2'h3: return SEG_MS_3;
        endcase
    endfunction

    logic [2:0] seg_q;
    logic [11:0] seg_cnt_q, seg_len;
    logic [1:0] pulses;
    logic spd_on;

    // Index 0 is segment 1, so an odd index is an even segment.
    assign seg_len = seg_q[0] ? seg_ms(time_q[T_EVEN_LO +: 2]) :
                     seg_ms(time_q[T_ODD_LO +: 2]);
    assign pulses = link1000_i ? 2'h3 : link100_i ? 2'h2 :
                    link10_i ? 2'h1 : 2'h0;
    assign spd_on = ~seg_q[0] & (seg_q[2:1] < pulses);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seg_q <= '0;
            seg_cnt_q <= '0;
        end else if (ms_tick) begin
            if (seg_cnt_q >= seg_len - 12'h001) begin
                seg_cnt_q <= '0;
                seg_q <= seg_q + 3'h1;
            end else begin
                seg_cnt_q <= seg_cnt_q + 12'h001;
            end
        end
    end

    // ****************************************************************
    // Single mode decode
    // ****************************************************************
    logic [10:0] st;
    always_comb begin
        st = '0;
        st[S_L10] = link10_i;
        st[S_L100] = link100_i;
        st[S_L1G] = link1000_i;
        st[S_LINK] = link10_i | link100_i | link1000_i;
        st[S_TX] = act_s[0];
        st[S_RX] = act_s[1];
        st[S_ACT] = act_s[0] | act_s[1];
        st[S_FDX] = full_duplex_i;
        st[S_COL] = collision_i;
        st[S_FIB] = fiber_link_i;
        st[S_SPD] = spd_on;
    end

    function automatic lsi_lamp_t on_if(input logic c);
        return c ? LMP_ON : LMP_OFF;
    endfunction

    function automatic lsi_lamp_t lamp(input int unsigned pin,
                                       input logic [3:0] c,
                                       input logic [10:0] s);
        lsi_lamp_t blk_act;
        blk_act = s[S_ACT] ? LMP_BLINK : LMP_ON;
        if (c[3:2] == CODE_FORCE) begin
            unique case (c[1:0])
                2'h0: return LMP_OFF;
                2'h1: return LMP_ON;
                2'h2: return LMP_HIZ;
                2'h3: return LMP_BLINK;
            endcase
        end
        if (c[3]) begin
            return LMP_OFF;
        end
        unique case (c[2:0])
            3'h0: return on_if(pin == 1 ? s[S_RX] : s[S_LINK]);
            3'h1: return s[S_LINK] ? blk_act : LMP_OFF;
            3'h2: begin
                if (pin == 2) begin
                    return s[S_FDX] ? (s[S_COL] ? LMP_BLINK : LMP_ON)
                                    : LMP_OFF;
                end
                if (pin == 1) begin
                    return s[S_LINK] ? (s[S_RX] ? LMP_BLINK : LMP_ON)
                                     : LMP_OFF;
                end
                return on_if(s[S_SPD]);
            end
            3'h3: return on_if(s[S_ACT]);
            3'h4: return s[S_ACT] ? LMP_BLINK : LMP_OFF;
            3'h5: return on_if(pin == 1 ? s[S_L100] | s[S_FIB] : s[S_TX]);
            3'h6: begin
                if (pin == 2) begin
                    return on_if(s[S_L10] | s[S_L1G]);
                end
                return on_if(pin == 1 ? s[S_L100] | s[S_L1G] : s[S_LINK]);
            end
            3'h7: begin
                if (pin == 0) begin
                    return on_if(s[S_L1G]);
                end
                return on_if(pin == 1 ? s[S_L100] : s[S_L10]);
            end
        endcase
    endfunction

    // ****************************************************************
    // Dual modes and mixing
    // ****************************************************************
    logic [2:0] pwm_q;
    logic dual;
    logic [1:0] mode;
    logic [1:0] dl_on, dl_mix;
    logic dl_blink;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_q <= '0;
        end else begin
            pwm_q <= pwm_q + 3'h1;
        end
    end

    assign dual = func_q[F_CODE_LO + 2 +: 2] == CODE_DUAL;
    assign mode = func_q[F_CODE_LO +: 2];

    // Bit 1 is output 1, bit 0 is output 0.
    always_comb begin
        dl_on = 2'b00;
        dl_mix = 2'b00;
        dl_blink = 1'b0;
        unique case (mode)
            2'h0: dl_mix = 2'b11;
            2'h1: begin
                dl_mix = 2'b11;
                dl_blink = 1'b1;
            end
            default: begin
                dl_blink = st[S_ACT];
                if (link1000_i) begin
                    dl_on = 2'b01;
                end else if (mode == 2'h2 ? link100_i : link10_i) begin
                    dl_mix = 2'b11;
                end else if (mode == 2'h2 ? link10_i : link100_i) begin
                    dl_on = 2'b10;
                end
            end
        endcase
    end

    // ****************************************************************
    // Interrupt and pin drive
    // ****************************************************************
    logic cp_act, fb_act, irq_act, irq_lvl, route;
    assign cp_act = |(copper_irq_stat_i & cen_q) | time_q[T_CFORCE];
    assign fb_act = |(fiber_irq_stat_i & fib_q[15:0]) | fib_q[FB_FORCE];
    assign irq_act = fiber_media_i ? fb_act : cp_act;
    // A polarity bit of one drives the active interrupt low.
    assign irq_lvl = irq_act ^ (fiber_media_i ? fib_q[FB_POL] :
                                time_q[T_CPOL]);
    assign route = time_q[T_ROUTE];

    logic [2:0] lit, hiz;
    for (genvar p = 0; p < 3; p++) begin : g_pin
        lsi_lamp_t l;
        logic [1:0] pol;
        logic [3:0] mix;
        assign l = lamp(p, func_q[p*4 +: 4], st);
        assign pol = pol_q[p*2 +: 2];
        assign mix = (p == 1) ? pol_q[P_MIX1_LO +: 4] : pol_q[P_MIX0_LO +: 4];
        always_comb begin
            hiz[p] = 1'b0;
            if (p < 2 && dual) begin
                lit[p] = (dl_on[p] | (dl_mix[p] & ({1'b0, pwm_q} < mix)))
                         & (~dl_blink | blink_q);
            end else begin
                lit[p] = (l == LMP_ON) | ((l == LMP_BLINK) & blink_q);
                hiz[p] = (l == LMP_HIZ);
            end
        end
        always_ff @(posedge sys_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                indicator_o[p] <= 1'b0;
                indicator_oe_o[p] <= 1'b0;
            end else if (p == 2 && route) begin
                indicator_o[p] <= irq_lvl;
                indicator_oe_o[p] <= 1'b1;
            end else begin
                indicator_o[p] <= lit[p] ? pol[0] : ~pol[0];
                indicator_oe_o[p] <= lit[p] | ~(hiz[p] | pol[1]);
            end
        end
    end

    assign stat_w = {22'h0, act_s, irq_act, seg_q, lit, spd_on};

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_route;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        route && !fiber_media_i |=>
            indicator_o[2] == ($past(cp_act) ^ $past(time_q[T_CPOL]));
    endproperty
    a_route: assert property (p_route)
        else $error("output 2 does not carry the interrupt");

    property p_lowact;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        route && !fiber_media_i && time_q[T_CPOL] && time_q[T_CFORCE]
            |=> !indicator_o[2] && indicator_oe_o[2];
    endproperty
    a_lowact: assert property (p_lowact)
        else $error("active low interrupt not driven low");

    property p_hiz;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !route && func_q[11:8] == 4'hA |=> !indicator_oe_o[2];
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("forced high-impedance output is driven");

    property p_foff;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !route && func_q[11:8] == 4'h8 && pol_q[5:4] == 2'h1
            |=> indicator_oe_o[2] && !indicator_o[2];
    endproperty
    a_foff: assert property (p_foff)
        else $error("forced off output not at off level");

    property p_gap;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        seg_q[0] || seg_q[2:1] == 2'h3 |-> !spd_on;
    endproperty
    a_gap: assert property (p_gap)
        else $error("speed pulse outside segments 1, 3, 5");

    property p_nolink;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !(link10_i | link100_i | link1000_i) |-> !spd_on;
    endproperty
    a_nolink: assert property (p_nolink)
        else $error("speed pulse without link");

    property p_seglen;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        $changed(seg_q) |-> $past(seg_cnt_q) >= $past(seg_len) - 12'h001;
    endproperty
    a_seglen: assert property (p_seglen)
        else $error("segment ended early");

    property p_act;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        tx_act_i || rx_act_i |-> st[S_ACT] ##1 (st[S_ACT] ||
            time_q[T_STR_LO +: 3] == 3'h0);
    endproperty
    a_act: assert property (p_act)
        else $error("activity not shown or not stretched");

    property p_offz;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !lit[0] && pol_q[1] |=> !indicator_oe_o[0];
    endproperty
    a_offz: assert property (p_offz)
        else $error("off state not released");

endmodule
`default_nettype wire

//--- common/lsi_pkg.sv
package lsi_pkg;

    // ****************************************************************
    // Clock and time base
    // ****************************************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned TICK_CYC_DEF = CLK_HZ / MS_PER_S;
    localparam int unsigned MSW = 12;

    // Segment periods, blink periods and stretch lengths in ms.
    localparam logic [11:0] SEG_MS_0 = 12'd84;
    localparam logic [11:0] SEG_MS_1 = 12'd170;
    localparam logic [11:0] SEG_MS_2 = 12'd340;
    localparam logic [11:0] SEG_MS_3 = 12'd670;
    localparam logic [11:0] BLK_MS_0 = 12'd42;
    localparam logic [11:0] STR_MS_1 = 12'd42;
    localparam logic [11:0] STR_MS_6 = 12'd1300;
    localparam logic [11:0] STR_MS_7 = 12'd2700;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OFS_FUNC = 8'h00;
    localparam logic [7:0] OFS_TIME = 8'h04;
    localparam logic [7:0] OFS_POL = 8'h08;
    localparam logic [7:0] OFS_CEN = 8'h0C;
    localparam logic [7:0] OFS_FIB = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    localparam logic [31:0] RST_FUNC = 32'h0000_0000;
    localparam logic [31:0] RST_TIME = 32'h0000_0000;
    localparam logic [31:0] RST_POL = 32'h0000_0015;
    localparam logic [31:0] RST_CEN = 32'h0000_0000;
    localparam logic [31:0] RST_FIB = 32'h0000_0000;

    localparam int unsigned F_CODE_LO = 0;
    localparam int unsigned T_ODD_LO = 0;
    localparam int unsigned T_EVEN_LO = 2;
    localparam int unsigned T_ROUTE = 7;
    localparam int unsigned T_BLINK_LO = 8;
    localparam int unsigned T_CPOL = 11;
    localparam int unsigned T_STR_LO = 12;
    localparam int unsigned T_CFORCE = 15;
    localparam int unsigned P_MIX0_LO = 8;
    localparam int unsigned P_MIX1_LO = 12;
    localparam int unsigned FB_FORCE = 16;
    localparam int unsigned FB_POL = 17;

    localparam logic [1:0] CODE_FORCE = 2'h2;
    localparam logic [1:0] CODE_DUAL = 2'h3;
    localparam logic [3:0] MIX_STEPS = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Status vector bit positions.
    localparam int unsigned S_LINK = 0;
    localparam int unsigned S_ACT = 1;
    localparam int unsigned S_TX = 2;
    localparam int unsigned S_RX = 3;
    localparam int unsigned S_FDX = 4;
    localparam int unsigned S_COL = 5;
    localparam int unsigned S_L10 = 6;
    localparam int unsigned S_L100 = 7;
    localparam int unsigned S_L1G = 8;
    localparam int unsigned S_FIB = 9;
    localparam int unsigned S_SPD = 10;

    typedef enum logic [1:0] {
        LMP_OFF,
        LMP_ON,
        LMP_BLINK,
        LMP_HIZ
    } lsi_lamp_t;

endpackage

//--- verification/lsi_lamp_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_lamp_model (
    input wire logic [2:0] pin_i,
    input wire logic [2:0] oe_i,
    input wire logic [2:0] act_high_i,
    output logic [2:0] lit_o
);
    // A released pin leaves its lamp dark, whatever level it drove last.
    assign lit_o = oe_i & ~(pin_i ^ act_high_i);
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
import lsi_pkg::*;
localparam int TK = 4;
localparam int PER = 8 * 84 * TK;
logic sys_clk_i = 0, rstn_i = 0, awvalid = 0, wvalid = 0, bready = 0;
logic arvalid = 0, rready = 0, txa = 0, rxa = 0, fib = 0, fdx = 0, p;
logic [7:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata, rd, cst = 0;
logic awready, wready, bvalid, arready, rvalid;
logic [1:0] bresp, rresp, rr;
logic [2:0] lnk = 0, ind, oe, lit;
int num_errors = 0, checks_done = 0, cyc = 0, n, k;
always #50 sys_clk_i = ~sys_clk_i;
lsi_led_ctrl #(.TICK_CYC(TK)) i_dut (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link10_i(lnk[0]), .link100_i(lnk[1]),
    .link1000_i(lnk[2]), .fiber_link_i(1'b0), .full_duplex_i(fdx),
    .collision_i(1'b0), .tx_act_i(txa), .rx_act_i(rxa),
    .fiber_media_i(fib), .copper_irq_stat_i(cst),
    .fiber_irq_stat_i(16'h0000), .indicator_o(ind), .indicator_oe_o(oe));
lsi_lamp_model i_lamp (.pin_i(ind), .oe_i(oe), .act_high_i(3'b111),
    .lit_o(lit));
// ****************************************************************
// Bus tasks and checks
// ****************************************************************
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        num_errors++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic pin(input logic [5:0] e);
    chk({26'h0, oe, ind}, {26'h0, e});
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge sys_clk_i);
    while (awready !== 1'b1) @(posedge sys_clk_i);
    awvalid <= 1'b0; wvalid <= 1'b0;
    @(posedge sys_clk_i);
    while (bvalid !== 1'b1) @(posedge sys_clk_i);
    bready <= 1'b0; rr = bresp;
    repeat (2) @(posedge sys_clk_i);
endtask
task automatic rd_reg(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    @(posedge sys_clk_i);
    while (arready !== 1'b1) @(posedge sys_clk_i);
    arvalid <= 1'b0;
    @(posedge sys_clk_i);
    while (rvalid !== 1'b1) @(posedge sys_clk_i);
    rready <= 1'b0; rd = rdata; rr = rresp;
    @(posedge sys_clk_i);
endtask
task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
// A hung handshake would otherwise stall the run forever.
always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
        num_errors++;
        close_out;
    end
end
// ****************************************************************
// Scenarios
// ****************************************************************
initial begin
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_reg(OFS_POL); chk(rd, RST_POL);
    pin(6'b111_000);
    rd_reg(8'h40); chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(OFS_STAT, 32'h0); chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(OFS_FUNC, 32'h800); pin(6'b111_000);
    wr(OFS_FUNC, 32'h900); pin(6'b111_100);
    chk({29'h0, lit}, 32'h4);
    wr(OFS_FUNC, 32'hA00); pin(6'b011_000);
    for (k = 0; k < 3; k++) begin
        lnk <= 3'b001 << k; repeat (3) @(posedge sys_clk_i);
        pin(6'b011_001);
    end
    lnk <= 3'b000; wr(OFS_FUNC, 32'h030); pin(6'b111_000);
    txa <= 1'b1; repeat (3) @(posedge sys_clk_i); pin(6'b111_010);
    txa <= 1'b0; rxa <= 1'b1; repeat (3) @(posedge sys_clk_i);
    pin(6'b111_010);
    rxa <= 1'b0;
    fdx <= 1'b1;
    wr(OFS_FUNC, 32'h230); pin(6'b111_100);
    fdx <= 1'b0;
    lnk <= 3'b100;
    wr(OFS_FUNC, 32'h03E); pin(6'b111_101);
    lnk <= 3'b001;
    repeat (3) @(posedge sys_clk_i);
    pin(6'b111_110);
    wr(OFS_POL, 32'h8817);
    wr(OFS_FUNC, 32'h03C); pin(6'b111_111);
    wr(OFS_FUNC, 32'h03F); pin(6'b111_111);
    wr(OFS_TIME, 32'h8080); chk({31'h0, ind[2]}, 32'h1);
    wr(OFS_TIME, 32'h8880); chk({31'h0, ind[2]}, 32'h0);
    wr(OFS_TIME, 32'h0080); wr(OFS_CEN, 32'h1);
    cst <= 32'h1; repeat (3) @(posedge sys_clk_i);
    chk({31'h0, ind[2]}, 32'h1);
    cst <= 32'h0; repeat (3) @(posedge sys_clk_i);
    chk({31'h0, ind[2]}, 32'h0);
    fib <= 1'b1; wr(OFS_FIB, 32'h10000);
    chk({31'h0, ind[2]}, 32'h1);
    wr(OFS_TIME, 32'h0); wr(OFS_FUNC, 32'h002);
    for (int s = 0; s < 4; s++) begin
        lnk <= (s == 3) ? 3'b000 : 3'b001 << s;
        repeat (PER) @(posedge sys_clk_i);
        n = 0; p = ind[0];
        repeat (PER) begin
            @(posedge sys_clk_i);
            if (ind[0] === 1'b1 && p === 1'b0) n++;
            p = ind[0];
        end
        chk(n, (s == 3) ? 0 : s + 1);
    end
    close_out;
end
endmodule
`default_nettype wire
